// [umd_pkg.sv]
// Package: offsets, fields, resets and types of the modem and data regs
`default_nettype none

package umd_pkg;

   // -----------------------------------------------------------------
   // Register indices (byte address = index * 4)
   // -----------------------------------------------------------------
   localparam int unsigned UMD_AW = 12;
   localparam logic [9:0] IDX_DATA = 10'h3f8;
   localparam logic [9:0] IDX_IER = 10'h3f9;
   localparam logic [9:0] IDX_IID = 10'h3fa;
   localparam logic [9:0] IDX_LCR = 10'h3fb;
   localparam logic [9:0] IDX_MOC = 10'h3fc;
   localparam logic [9:0] IDX_LSR = 10'h3fd;
   localparam logic [9:0] IDX_MLS = 10'h3fe;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int unsigned MOC_DTR = 0;
   localparam int unsigned MOC_RTS = 1;
   localparam int unsigned MOC_OUT1 = 2;
   localparam int unsigned MOC_OUT2 = 3;
   localparam int unsigned MOC_LOOP = 4;
   localparam int unsigned IER_RXD = 0;
   localparam int unsigned IER_THE = 1;
   localparam int unsigned IER_LST = 2;
   localparam int unsigned IER_MDM = 3;
   localparam int unsigned LCR_DIVACC = 7;

   // -----------------------------------------------------------------
   // Interrupt identity codes: no interrupt, then highest priority first
   // -----------------------------------------------------------------
   localparam logic [2:0] IID_NONE = 3'h1;
   localparam logic [2:0] IID_LST = 3'h6;
   localparam logic [2:0] IID_RXD = 3'h4;
   localparam logic [2:0] IID_THE = 3'h2;
   localparam logic [2:0] IID_MDM = 3'h0;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [4:0] MOC_RST = 5'h00;
   localparam logic [3:0] IER_RST = 4'h0;
   localparam logic [7:0] LCR_RST = 8'h00;
   localparam logic [15:0] DIV_RST = 16'h0010;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} umd_rx_t;
   typedef enum logic {TX_IDLE, TX_SHIFT} umd_tx_t;

endpackage

`default_nettype wire

// [umd_top.sv]
// Modem status, modem control and data registers with a serial core
//
// Behaviour
// RULE1 - Software may write low four state bits
// RULE2 - Written ones raise modem interrupt, cleared normally
// RULE3 - Software restores registers before clearing loopback
// RULE4 - Control bits 5 to 7 always read zero
// RULE5 - Change flags set on change, clear on read
// RULE6 - Bit 0 flags clear-to-send change
// RULE7 - Bit 1 flags set-ready change
// RULE8 - Bit 2 flags ring on-to-off only
// RULE9 - Bit 3 flags carrier-detect change
// RULE10 - Any change flag raises modem interrupt
// RULE11 - Bit 4 is clear-to-send, loop gives request
// RULE12 - Bit 5 is set-ready, loop gives terminal-ready
// RULE13 - Bit 6 is ring, loop gives first auxiliary
// RULE14 - Bit 7 is carrier, loop gives second auxiliary
// RULE15 - Data read returns receive buffer
// RULE16 - Data write loads transmit holding
// RULE17 - First received bit lands in bit 0
// RULE18 - Bit 0 is transmitted first
// RULE19 - Loopback marks output, loops data and modem lines
// RULE20 - Modem output pins are inverted control bits
// RULE21 - Modem interrupt needs enable bit 3
// RULE22 - Modem interrupt has lowest priority
// RULE23 - Inputs synchronised; change beats same-cycle read
`default_nettype none

module umd_top
   import umd_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [UMD_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sin,
   output logic sout,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ri_n,
   input wire logic dcd_n,
   output logic dtr_n,
   output logic rts_n,
   output logic out1_n,
   output logic out2_n,
   output logic interrupt_output
);

   if (DIV_W < 8 || DIV_W > 16) begin : g_bad_width
      $error("umd_top: DIV_W must lie in 8..16");
   end

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [4:0] sy1_ff, sy2_ff;
   logic [4:0] moc_ff;
   logic [3:0] ier_ff;
   logic [7:0] lcr_ff;
   logic [15:0] div_ff;
   logic [7:0] hold_ff, rxbuf_ff, rsh_ff;
   logic thre_ff, dr_ff, oe_ff, irq_ff, err_ff;
   logic [3:0] delta_ff, nxt_delta, prev_ff, live_on, evt, clr;
   logic [31:0] prdata_ff;
   logic [7:0] rd_val;
   logic [9:0] idx;
   logic setup, acc, wr, rd, div_acc, loop, hit;
   logic [2:0] iid;
   logic [15:0] div_eff;
   umd_tx_t tx_state;
   umd_rx_t rx_state;
   logic [9:0] tsr_ff;
   logic [3:0] tbits_ff, rbits_ff;
   logic [15:0] tcnt_ff, rcnt_ff;
   logic tx_load, rx_done, rx_in, temt;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   assign idx = paddr[UMD_AW-1:2];
   assign setup = psel & ~penable;
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign div_acc = lcr_ff[LCR_DIVACC];
   assign loop = moc_ff[MOC_LOOP];
   assign hit = (idx >= IDX_DATA) && (idx <= IDX_MLS);
   assign pready = acc;
   assign pslverr = acc & err_ff;
   assign prdata = prdata_ff;
   assign div_eff = (div_ff == 16'h0000) ? 16'h0001 : div_ff;

   // Two-flop synchronisers for sin and modem lines
   always_ff @(posedge pclk or negedge presetn) begin // see RULE23
      if (!presetn) begin
         sy1_ff <= 5'h1f;
         sy2_ff <= 5'h1f;
      end else begin
         sy1_ff <= {dcd_n, ri_n, dsr_n, cts_n, sin};
         sy2_ff <= sy1_ff;
      end
   end

   // -----------------------------------------------------------------
   // Modem lines and change flags
   // -----------------------------------------------------------------
   // Lines as "on" levels; loopback takes them from the control bits
   assign live_on = loop ? // see RULE19
      {moc_ff[MOC_OUT2], moc_ff[MOC_OUT1], // see RULE13, RULE14
       moc_ff[MOC_DTR], moc_ff[MOC_RTS]} // see RULE11, RULE12
      : ~sy2_ff[4:1];
   assign evt[0] = live_on[0] ^ prev_ff[0]; // see RULE6
   assign evt[1] = live_on[1] ^ prev_ff[1]; // see RULE7
   assign evt[2] = prev_ff[2] & ~live_on[2]; // see RULE8
   assign evt[3] = live_on[3] ^ prev_ff[3]; // see RULE9
   // Clear only the flags the read actually reported
   assign clr = (rd && idx == IDX_MLS) ? prdata_ff[3:0] : 4'h0;

   // Software write loads the flags; new changes always win
   always_comb begin // see RULE1, RULE2, RULE5, RULE23
      if (wr && idx == IDX_MLS) begin
         nxt_delta = pwdata[3:0] | evt;
      end else begin
         nxt_delta = (delta_ff & ~clr) | evt;
      end
   end

   // Flag and previous-level storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delta_ff <= 4'h0;
         prev_ff <= 4'h0;
      end else begin
         delta_ff <= nxt_delta;
         prev_ff <= live_on;
      end
   end

   // Output pins, inverted; inactive while looped back
   assign dtr_n = loop | ~moc_ff[MOC_DTR]; // see RULE20, RULE19
   assign rts_n = loop | ~moc_ff[MOC_RTS]; // see RULE20
   assign out1_n = loop | ~moc_ff[MOC_OUT1]; // see RULE20
   assign out2_n = loop | ~moc_ff[MOC_OUT2]; // see RULE20

   // -----------------------------------------------------------------
   // Control registers
   // -----------------------------------------------------------------
   // Plain writable registers; upper control bits are not stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         moc_ff <= MOC_RST;
         ier_ff <= IER_RST;
         lcr_ff <= LCR_RST;
         div_ff <= DIV_RST;
      end else if (wr) begin
         case (idx)
            IDX_MOC: moc_ff <= pwdata[4:0]; // see RULE4, RULE3
            IDX_LCR: lcr_ff <= pwdata[7:0];
            IDX_IER: begin
               if (div_acc) begin
                  div_ff[15:8] <= pwdata[7:0];
               end else begin
                  ier_ff <= pwdata[3:0];
               end
            end
            IDX_DATA: begin
               if (div_acc) begin
                  div_ff[7:0] <= pwdata[7:0];
               end
            end
            default: ;
         endcase
      end
   end

   // Transmit holding register and its empty flag
   always_ff @(posedge pclk or negedge presetn) begin // see RULE16
      if (!presetn) begin
         hold_ff <= 8'h00;
         thre_ff <= 1'b1;
      end else if (wr && idx == IDX_DATA && !div_acc) begin
         hold_ff <= pwdata[7:0];
         thre_ff <= 1'b0;
      end else if (tx_load) begin
         thre_ff <= 1'b1;
      end
   end

   // Receive data ready and overrun; arrivals beat clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dr_ff <= 1'b0;
         oe_ff <= 1'b0;
         rxbuf_ff <= 8'h00;
      end else begin
         if (rx_done) begin
            rxbuf_ff <= rsh_ff;
            dr_ff <= 1'b1;
         end else if (rd && idx == IDX_DATA && !div_acc) begin
            dr_ff <= 1'b0;
         end
         if (rx_done && dr_ff) begin
            oe_ff <= 1'b1;
         end else if (rd && idx == IDX_LSR) begin
            oe_ff <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Interrupt priority
   // -----------------------------------------------------------------
   // Line status, then rx data, then tx empty, then modem last
   always_comb begin // see RULE10, RULE21, RULE22
      if (oe_ff && ier_ff[IER_LST]) begin
         iid = IID_LST;
      end else if (dr_ff && ier_ff[IER_RXD]) begin
         iid = IID_RXD;
      end else if (thre_ff && ier_ff[IER_THE]) begin
         iid = IID_THE;
      end else if ((|delta_ff) && ier_ff[IER_MDM]) begin
         iid = IID_MDM;
      end else begin
         iid = IID_NONE;
      end
   end

   // Registered interrupt line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= (iid != IID_NONE);
      end
   end
   assign interrupt_output = irq_ff;

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   assign temt = thre_ff & (tx_state == TX_IDLE);

   // Read value selection
   always_comb begin
      case (idx)
         IDX_DATA: rd_val = div_acc ? div_ff[7:0] : rxbuf_ff; // see RULE15
         IDX_IER: rd_val = div_acc ? div_ff[15:8] : {4'h0, ier_ff};
         IDX_IID: rd_val = {5'h00, iid};
         IDX_LCR: rd_val = lcr_ff;
         IDX_MOC: rd_val = {3'h0, moc_ff}; // see RULE4
         IDX_LSR: rd_val = {1'b0, temt, thre_ff, 3'h0, oe_ff, dr_ff};
         IDX_MLS: rd_val = {live_on, delta_ff}; // see RULE11, RULE14
         default: rd_val = 8'h00;
      endcase
   end

   // Read data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
         err_ff <= 1'b0;
      end else if (setup) begin
         prdata_ff <= {24'h00_0000, rd_val};
         err_ff <= ~hit;
      end
   end

   // -----------------------------------------------------------------
   // Transmitter, 8N1, one bit per div_eff cycles
   // -----------------------------------------------------------------
   assign tx_load = (tx_state == TX_IDLE) && !thre_ff;

   // Shifter sends start, bit 0 first, then stop
   always_ff @(posedge pclk or negedge presetn) begin // see RULE18
      if (!presetn) begin
         tx_state <= TX_IDLE;
         tsr_ff <= 10'h3ff;
         tbits_ff <= 4'h0;
         tcnt_ff <= 16'h0000;
      end else begin
         case (tx_state)
            TX_IDLE: begin
               if (tx_load) begin
                  tsr_ff <= {1'b1, hold_ff, 1'b0};
                  tbits_ff <= 4'h0;
                  tcnt_ff <= div_eff - 16'h0001;
                  tx_state <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (tcnt_ff == 16'h0000) begin
                  tsr_ff <= {1'b1, tsr_ff[9:1]};
                  tbits_ff <= tbits_ff + 4'h1;
                  tcnt_ff <= div_eff - 16'h0001;
                  if (tbits_ff == 4'h9) begin
                     tx_state <= TX_IDLE;
                  end
               end else begin
                  tcnt_ff <= tcnt_ff - 16'h0001;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end
   assign sout = loop | tsr_ff[0]; // see RULE19

   // -----------------------------------------------------------------
   // Receiver
   // -----------------------------------------------------------------
   assign rx_in = loop ? tsr_ff[0] : sy2_ff[0]; // see RULE19
   assign rx_done = (rx_state == RX_STOP) && (rcnt_ff == 16'h0000);

   // Mid-bit sampling; first bit shifts down to bit 0
   always_ff @(posedge pclk or negedge presetn) begin // see RULE17
      if (!presetn) begin
         rx_state <= RX_IDLE;
         rsh_ff <= 8'h00;
         rbits_ff <= 4'h0;
         rcnt_ff <= 16'h0000;
      end else begin
         case (rx_state)
            RX_IDLE: begin
               if (!rx_in) begin
                  rcnt_ff <= {1'b0, div_eff[15:1]};
                  rx_state <= RX_START;
               end
            end
            RX_START: begin
               if (rcnt_ff != 16'h0000) begin
                  rcnt_ff <= rcnt_ff - 16'h0001;
               end else if (!rx_in) begin
                  rcnt_ff <= div_eff - 16'h0001;
                  rbits_ff <= 4'h0;
                  rx_state <= RX_DATA;
               end else begin
                  rx_state <= RX_IDLE;
               end
            end
            RX_DATA: begin
               if (rcnt_ff != 16'h0000) begin
                  rcnt_ff <= rcnt_ff - 16'h0001;
               end else begin
                  rsh_ff <= {rx_in, rsh_ff[7:1]};
                  rbits_ff <= rbits_ff + 4'h1;
                  rcnt_ff <= div_eff - 16'h0001;
                  if (rbits_ff == 4'h7) begin
                     rx_state <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rcnt_ff != 16'h0000) begin
                  rcnt_ff <= rcnt_ff - 16'h0001;
               end else begin
                  rx_state <= RX_IDLE;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   a_moc_high_zero: // see RULE4
      assert property (@(posedge pclk) disable iff (!presetn)
         setup && idx == IDX_MOC |=> prdata_ff[7:5] == 3'h0)
      else $error("control bits 5-7 not zero");

   a_flag_on_change: // see RULE6
      assert property (@(posedge pclk) disable iff (!presetn)
         live_on[0] != prev_ff[0] |=> delta_ff[0])
      else $error("clear-to-send change not flagged");

   a_ring_rise_quiet: // see RULE8
      assert property (@(posedge pclk) disable iff (!presetn)
         !prev_ff[2] && live_on[2] && !wr && clr[2] == 1'b0
         |=> delta_ff[2] == $past(delta_ff[2]))
      else $error("ring rising edge set the flag");

   a_read_clears: // see RULE5
      assert property (@(posedge pclk) disable iff (!presetn)
         rd && idx == IDX_MLS && evt == 4'h0
         |=> delta_ff == ($past(delta_ff) & ~$past(prdata_ff[3:0])))
      else $error("state read did not clear flags");

   a_loop_mirror: // see RULE11
      assert property (@(posedge pclk) disable iff (!presetn)
         loop && setup && idx == IDX_MLS
         |=> prdata_ff[4] == $past(moc_ff[MOC_RTS]))
      else $error("loopback state bit 4 wrong");

   a_out_invert: // see RULE20
      assert property (@(posedge pclk) disable iff (!presetn)
         !loop |-> {dtr_n, out2_n} ==
         {~moc_ff[MOC_DTR], ~moc_ff[MOC_OUT2]})
      else $error("modem output not inverted");

   a_sout_mark: // see RULE19
      assert property (@(posedge pclk) disable iff (!presetn)
         loop |-> sout && dtr_n && rts_n)
      else $error("loopback output not at mark");

   a_modem_gate: // see RULE21
      assert property (@(posedge pclk) disable iff (!presetn)
         !ier_ff[IER_MDM] |-> iid != IID_MDM)
      else $error("modem interrupt without enable");

   a_modem_lowest: // see RULE22
      assert property (@(posedge pclk) disable iff (!presetn)
         (|delta_ff) && ier_ff[IER_MDM] && iid != IID_MDM
         |-> iid != IID_NONE)
      else $error("modem interrupt lost");

   a_data_read: // see RULE15
      assert property (@(posedge pclk) disable iff (!presetn)
         setup && idx == IDX_DATA && !div_acc
         |=> prdata_ff[7:0] == $past(rxbuf_ff))
      else $error("data read not receive buffer");

   a_data_write: // see RULE16
      assert property (@(posedge pclk) disable iff (!presetn)
         wr && idx == IDX_DATA && !div_acc
         |=> hold_ff == $past(pwdata[7:0]) && !thre_ff)
      else $error("holding register not loaded");

   a_tx_lsb_first: // see RULE18
      assert property (@(posedge pclk) disable iff (!presetn)
         tx_load |=> !tsr_ff[0] && tsr_ff[1] == $past(hold_ff[0]))
      else $error("transmit order wrong");

endmodule // umd_top

`default_nettype wire

// [umd_modem_model.sv]
// Modem model: status lines, serial frames in and out
`default_nettype none

module umd_modem_model #(
   parameter int BIT_CLKS = 4
) (
   input wire logic pclk,
   input wire logic sout,
   output logic sin,
   output logic cts_n,
   output logic dsr_n,
   output logic ri_n,
   output logic dcd_n
);
   timeunit 1ns;
   timeprecision 100ps;

   // Lines idle at mark, all status lines off
   initial begin
      sin = 1'b1;
      {dcd_n, ri_n, dsr_n, cts_n} = 4'hf;
   end

   // Set status lines, packed carrier, ring, set-ready, clear-to-send
   task automatic set_lines(input logic [3:0] lv);
      @(posedge pclk);
      {dcd_n, ri_n, dsr_n, cts_n} <= lv;
   endtask

   // One 8N1 frame, low bit first, stop bit leaves line at mark
   task automatic send(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge pclk);
         sin <= fr[i];
         repeat (BIT_CLKS - 1) @(posedge pclk);
      end
   endtask

   // Frame capture, sampled mid-bit, first bit into bit 0
   task automatic recv(output logic [7:0] b);
      @(negedge sout);
      repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         b[i] = sout;
         repeat (BIT_CLKS) @(posedge pclk);
      end
   endtask
endmodule // umd_modem_model

`default_nettype wire

// [uart_modem_status_data_regs_tb.sv]
// Testbench: APB tests of modem status, control and data registers
`default_nettype none

module uart_modem_status_data_regs_tb import umd_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // Signals and byte addresses
   // ------------------------------------------------------------
   localparam logic [11:0] A_DATA = {IDX_DATA, 2'b00};
   localparam logic [11:0] A_IER = {IDX_IER, 2'b00};
   localparam logic [11:0] A_IID = {IDX_IID, 2'b00};
   localparam logic [11:0] A_LCR = {IDX_LCR, 2'b00};
   localparam logic [11:0] A_MOC = {IDX_MOC, 2'b00};
   localparam logic [11:0] A_LSR = {IDX_LSR, 2'b00};
   localparam logic [11:0] A_MLS = {IDX_MLS, 2'b00};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic sin, sout, cts_n, dsr_n, ri_n, dcd_n, irq, err;
   logic dtr_n, rts_n, out1_n, out2_n;
   logic [7:0] rb;
   int n_mismatch, num_checks;
   logic [3:0] lv_tab [6] = '{4'he, 4'hc, 4'h8, 4'hc, 4'h4, 4'hf};
   logic [7:0] ms_tab [6] = '{8'h11, 8'h32, 8'h70, 8'h34, 8'hb8, 8'h0b};

   // Clock of 8 ns
   initial pclk = 1'b0;
   always #4 pclk = ~pclk;

   umd_top #(.DIV_W(16)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sin(sin), .sout(sout), .cts_n(cts_n),
      .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .dtr_n(dtr_n),
      .rts_n(rts_n), .out1_n(out1_n), .out2_n(out2_n),
      .interrupt_output(irq));

   umd_modem_model #(.BIT_CLKS(4)) modem (.pclk(pclk), .sout(sout),
      .sin(sin), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
      .dcd_n(dcd_n));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   // Poll line status until a character is ready
   task automatic wait_rx();
      do begin
         apb(1'b0, A_LSR, 32'h0000_0000);
      end while (rd[0] !== 1'b1);
   endtask

   task automatic close_out();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      close_out();
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      n_mismatch = 0;
      num_checks = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      idle(6);
      apb(1'b0, A_MLS, 32'h0000_0000);
      rdc(A_MLS, 32'h0000_0000);
      // Walk the status lines through every change
      for (int i = 0; i < 6; i++) begin
         modem.set_lines(lv_tab[i]);
         idle(6);
         rdc(A_MLS, {24'h0, ms_tab[i]});
         rdc(A_MLS, {24'h0, ms_tab[i] & 8'hf0});
      end
      // Modem interrupt, enable gating and software-set flags
      wr(A_IER, 32'h0000_0008);
      modem.set_lines(4'he);
      idle(6);
      chk({31'h0, irq}, 32'h0000_0001);
      rdc(A_MLS, 32'h0000_0011);
      idle(2);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(A_IER, 32'h0000_0000);
      modem.set_lines(4'hf);
      idle(6);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(A_IER, 32'h0000_0008);
      idle(2);
      chk({31'h0, irq}, 32'h0000_0001);
      rdc(A_MLS, 32'h0000_0001);
      wr(A_MLS, 32'h0000_0004);
      idle(2);
      chk({31'h0, irq}, 32'h0000_0001);
      rdc(A_MLS, 32'h0000_0004);
      idle(2);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(A_IER, 32'h0000_000a);
      wr(A_MLS, 32'h0000_0001);
      rdc(A_IID, {29'h0, IID_THE});
      rdc(A_MLS, 32'h0000_0001);
      wr(A_IER, 32'h0000_0000);
      // Control bits and inverted pins
      wr(A_MOC, 32'h0000_00e5);
      rdc(A_MOC, 32'h0000_0005);
      chk({28'h0, out2_n, out1_n, rts_n, dtr_n}, 32'h0000_000a);
      // Divisor of 4 clocks a bit, 8N1
      wr(A_LCR, 32'h0000_0080);
      wr(A_DATA, 32'h0000_0004);
      wr(A_IER, 32'h0000_0000);
      wr(A_LCR, 32'h0000_0003);
      // Loopback of modem lines and serial data
      wr(A_MOC, 32'h0000_001a);
      idle(6);
      chk({27'h0, sout, out2_n, out1_n, rts_n, dtr_n}, 32'h1f);
      rdc(A_MLS, 32'h0000_0099);
      wr(A_DATA, 32'h0000_00a5);
      idle(8);
      chk({31'h0, sout}, 32'h0000_0001);
      wait_rx();
      rdc(A_DATA, 32'h0000_00a5);
      wr(A_MOC, 32'h0000_0010);
      wr(A_MOC, 32'h0000_0000);
      idle(6);
      apb(1'b0, A_MLS, 32'h0000_0000);
      // External serial traffic both ways
      modem.send(8'h35);
      wait_rx();
      wr(A_IER, 32'h0000_0001);
      rdc(A_IID, {29'h0, IID_RXD});
      wr(A_IER, 32'h0000_0000);
      rdc(A_DATA, 32'h0000_0035);
      fork
         modem.recv(rb);
         wr(A_DATA, 32'h0000_0096);
      join
      chk({24'h0, rb}, 32'h0000_0096);
      // Unmapped place is refused
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk({31'h0, err}, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      close_out();
   end
endmodule // uart_modem_status_data_regs_tb

`default_nettype wire
